// ### src/cdr_ctrl_pkg.sv
// Register map, field positions and timing constants of the CDR control
package cdr_ctrl_pkg;

   // ****************************************************************
   // Serial slave address
   // ****************************************************************
   localparam logic       ADDR_MSB_FIXED   = 1'b1;
   localparam logic [4:0] ADDR_LOW_FIXED   = 5'h00;
   localparam int         BYTE_BITS        = 8;
   localparam logic [3:0] BIT_COUNT_FULL   = 4'h8;

   // ****************************************************************
   // Register subaddresses (eight in all)
   // ****************************************************************
   localparam int         NUM_REGS         = 8;
   localparam logic [2:0] SUB_REF_CONTROL  = 3'h0;
   localparam logic [2:0] SUB_AUX_CONTROL  = 3'h1;
   localparam logic [2:0] SUB_OUT_CONTROL  = 3'h2;
   localparam logic [2:0] SUB_STATUS       = 3'h3;
   localparam logic [2:0] SUB_LAST         = 3'h7;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int         REF_LOCK_BIT     = 0;
   localparam int         FINE_RATE_BIT    = 1;
   localparam int         RATIO_LSB        = 2;
   localparam int         RATIO_MSB        = 5;
   localparam int         RANGE_LSB        = 6;
   localparam int         RANGE_MSB        = 7;
   localparam int         AUX_ACQ_BIT      = 5;
   localparam int         AUX_STICKY_CLR   = 6;
   localparam int         AUX_STATIC_BIT   = 7;
   localparam int         OUT_SQ_MODE_BIT  = 1;
   localparam int         STAT_LOL_BIT     = 0;
   localparam int         STAT_STICKY_BIT  = 4;
   localparam logic [7:0] REF_CONTROL_RST  = 8'h00;
   localparam logic [7:0] AUX_CONTROL_RST  = 8'h00;
   localparam logic [7:0] OUT_CONTROL_RST  = 8'h00;

   // ****************************************************************
   // Harmonic check window, in data transitions of the new rate
   // ****************************************************************
   localparam int         HARM_TRANSITIONS = 16384;

endpackage : cdr_ctrl_pkg

// ### src/i2c_line_events.sv
// Start, stop and clock edge detection on the two-wire serial lines
`timescale 1ns/10ps
module i2c_line_events (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      start_o,
   output logic      stop_o,
   output logic      scl_rise_o,
   output logic      scl_fall_o,
   output logic      sda_o
);

   logic scl_r;
   logic sda_r;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         scl_r <= 1'b1;
         sda_r <= 1'b1;
      end else begin
         scl_r <= scl_i;
         sda_r <= sda_i;
      end
   end

   // Data moving while the clock stays high marks start or stop
   assign start_o    = scl_r & scl_i & sda_r & ~sda_i;
   assign stop_o     = scl_r & scl_i & ~sda_r & sda_i;
   assign scl_rise_o = ~scl_r & scl_i;
   assign scl_fall_o = scl_r & ~scl_i;
   assign sda_o      = sda_i;

endmodule : i2c_line_events

// ### src/cdr_control_i2c_slave.sv
// Serial register port, lock indicator and squelch control of a CDR
`timescale 1ns/10ps
module cdr_control_i2c_slave
   import cdr_ctrl_pkg::*;
#(
   parameter int HARM_COUNT = HARM_TRANSITIONS
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       addr_select_pin_i,
   input  wire logic       squelch_i,
   input  wire logic       rec_clock_i,
   input  wire logic       rec_data_i,
   input  wire logic       freq_within_i,
   input  wire logic       freq_error_i,
   input  wire logic       harm_suspect_i,
   input  wire logic       data_transition_i,
   output logic            recovered_clock_out_o,
   output logic            recovered_data_out_o,
   output logic            loss_of_lock_o,
   output logic            acq_restart_o,
   output logic            ref_lock_en_o,
   output logic            fine_rate_en_o,
   output logic [1:0]      ref_range_o,
   output logic [3:0]      ref_ratio_o
);

   // ****************************************************************
   // Serial slave state machine
   // ****************************************************************
   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_ADDR     = 9'h002,
      ST_ACK_ADDR = 9'h004,
      ST_SUB      = 9'h008,
      ST_ACK_SUB  = 9'h010,
      ST_WRITE    = 9'h020,
      ST_ACK_WR   = 9'h040,
      ST_READ     = 9'h080,
      ST_ACK_RD   = 9'h100
   } slave_state_t;

   slave_state_t state_r;
   logic [7:0]   shift_r;
   logic [7:0]   tx_r;
   logic [3:0]   bitcnt_r;
   logic [2:0]   ptr_r;
   logic         rw_r;
   logic         mack_r;
   logic         sda_oe_r;
   logic [7:0]   ref_ctl_r;
   logic [7:0]   aux_ctl_r;
   logic [7:0]   out_ctl_r;
   logic         lol_r;
   logic         lol_pin_r;
   logic         sticky_r;
   logic         acq_pulse_r;
   logic         clk_out_r;
   logic         data_out_r;
   logic [$clog2(HARM_COUNT+1)-1:0] harm_cnt_r;

   wire start_w;
   wire stop_w;
   wire rise_w;
   wire fall_w;
   wire sda_w;

   i2c_line_events u_events (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .start_o    (start_w),
      .stop_o     (stop_w),
      .scl_rise_o (rise_w),
      .scl_fall_o (fall_w),
      .sda_o      (sda_w)
   );

   // Saturating step keeps reads parked on the last register
   function automatic logic [2:0] next_ptr(input logic [2:0] p);
      next_ptr = (p == SUB_LAST) ? SUB_LAST : p + 3'h1;
   endfunction : next_ptr

   // Registers come in as arguments so the caller sees every change
   function automatic logic [7:0] reg_read(input logic [2:0] p,
                                           input logic [7:0] r_ref,
                                           input logic [7:0] r_aux,
                                           input logic [7:0] r_out,
                                           input logic [7:0] stat);
      reg_read = (p == SUB_REF_CONTROL) ? r_ref :
                 (p == SUB_AUX_CONTROL) ? r_aux :
                 (p == SUB_OUT_CONTROL) ? r_out :
                 (p == SUB_STATUS)      ? stat  : 8'h00;
   endfunction : reg_read

   wire [6:0] own_addr_w   = {ADDR_MSB_FIXED, addr_select_pin_i,
                              ADDR_LOW_FIXED};
   wire       byte_done_w  = fall_w & (bitcnt_r == BIT_COUNT_FULL);
   wire       addr_hit_w   = shift_r[7:1] == own_addr_w;
   wire       sub_ok_w     = shift_r < 8'(NUM_REGS);
   wire       wr_strobe_w  = (state_r == ST_WRITE) & byte_done_w;
   wire [7:0] status_w     = 8'({sticky_r, 3'h0, lol_r}) & 8'h11;
   wire [2:0] rd_ptr_w     = (state_r == ST_ACK_RD) ? next_ptr(ptr_r)
                                                     : ptr_r;
   wire [7:0] rd_byte_w    = reg_read(rd_ptr_w, ref_ctl_r, aux_ctl_r,
                                      out_ctl_r, status_w);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_r  <= ST_IDLE;
         shift_r  <= 8'h00;
         tx_r     <= 8'h00;
         bitcnt_r <= 4'h0;
         ptr_r    <= 3'h0;
         rw_r     <= 1'b0;
         mack_r   <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (stop_w) begin
         state_r  <= ST_IDLE;
         sda_oe_r <= 1'b0;
      end else if (start_w) begin
         state_r  <= ST_ADDR;
         bitcnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end else begin
         if (rise_w) begin
            shift_r  <= {shift_r[6:0], sda_w};
            bitcnt_r <= bitcnt_r + 4'h1;
            if (state_r == ST_ACK_RD) begin
               mack_r <= ~sda_w;
            end
         end
         unique case (state_r)
            ST_IDLE: begin
            end
            ST_ADDR: begin
               if (byte_done_w) begin
                  if (addr_hit_w) begin
                     state_r  <= ST_ACK_ADDR;
                     rw_r     <= shift_r[0];
                     sda_oe_r <= 1'b1;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (fall_w) begin
                  bitcnt_r <= 4'h0;
                  if (rw_r) begin
                     state_r  <= ST_READ;
                     tx_r     <= {rd_byte_w[6:0], 1'b0};
                     sda_oe_r <= ~rd_byte_w[7];
                  end else begin
                     state_r  <= ST_SUB;
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            ST_SUB: begin
               if (byte_done_w) begin
                  if (sub_ok_w) begin
                     state_r  <= ST_ACK_SUB;
                     ptr_r    <= shift_r[2:0];
                     sda_oe_r <= 1'b1;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_ACK_SUB, ST_ACK_WR: begin
               if (fall_w) begin
                  state_r  <= ST_WRITE;
                  bitcnt_r <= 4'h0;
                  sda_oe_r <= 1'b0;
               end
            end
            ST_WRITE: begin
               if (byte_done_w) begin
                  state_r  <= ST_ACK_WR;
                  ptr_r    <= next_ptr(ptr_r);
                  sda_oe_r <= 1'b1;
               end
            end
            ST_READ: begin
               if (byte_done_w) begin
                  state_r  <= ST_ACK_RD;
                  sda_oe_r <= 1'b0;
               end else if (fall_w) begin
                  tx_r     <= {tx_r[6:0], 1'b0};
                  sda_oe_r <= ~tx_r[7];
               end
            end
            ST_ACK_RD: begin
               if (fall_w) begin
                  if (mack_r) begin
                     state_r  <= ST_READ;
                     ptr_r    <= rd_ptr_w;
                     bitcnt_r <= 4'h0;
                     tx_r     <= {rd_byte_w[6:0], 1'b0};
                     sda_oe_r <= ~rd_byte_w[7];
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   // Software must not set both reference enables; no guard is added
   // so that a readback shows exactly what was written.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ref_ctl_r <= REF_CONTROL_RST;
         aux_ctl_r <= AUX_CONTROL_RST;
         out_ctl_r <= OUT_CONTROL_RST;
      end else if (wr_strobe_w) begin
         if (ptr_r == SUB_REF_CONTROL) begin
            ref_ctl_r <= shift_r;
         end
         if (ptr_r == SUB_AUX_CONTROL) begin
            aux_ctl_r <= shift_r;
         end
         if (ptr_r == SUB_OUT_CONTROL) begin
            out_ctl_r <= shift_r;
         end
      end
   end

   wire aux_wr_w   = wr_strobe_w & (ptr_r == SUB_AUX_CONTROL);
   wire ref_wr_w   = wr_strobe_w & (ptr_r == SUB_REF_CONTROL);
   wire acq_cmd_w  = aux_wr_w & aux_ctl_r[AUX_ACQ_BIT]
                     & ~shift_r[AUX_ACQ_BIT];
   wire clr_cmd_w  = aux_wr_w & aux_ctl_r[AUX_STICKY_CLR]
                     & ~shift_r[AUX_STICKY_CLR];
   wire relock_w   = ref_wr_w & ~ref_ctl_r[REF_LOCK_BIT]
                     & shift_r[REF_LOCK_BIT];
   wire ref_mode_w = ref_ctl_r[REF_LOCK_BIT];

   // ****************************************************************
   // Lock indicator and harmonic check
   // ****************************************************************
   wire harm_hit_w = harm_cnt_r == ($clog2(HARM_COUNT+1))'(HARM_COUNT - 1)
                     & data_transition_i;
   wire set_lol_w  = freq_error_i | harm_hit_w | acq_cmd_w | relock_w;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         harm_cnt_r <= '0;
      end else if (ref_mode_w | lol_r | ~harm_suspect_i | harm_hit_w) begin
         harm_cnt_r <= '0;
      end else if (data_transition_i) begin
         harm_cnt_r <= harm_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         lol_r       <= 1'b1;
         sticky_r    <= 1'b0;
         acq_pulse_r <= 1'b0;
         lol_pin_r   <= 1'b1;
      end else begin
         if (set_lol_w) begin
            lol_r <= 1'b1;
         end else if (freq_within_i) begin
            lol_r <= 1'b0;
         end
         if (set_lol_w | lol_r) begin
            sticky_r <= 1'b1;
         end else if (clr_cmd_w) begin
            sticky_r <= 1'b0;
         end
         acq_pulse_r <= set_lol_w & ~lol_r;
         // Pin trails the flags by one clock so it leaves a flip-flop
         lol_pin_r   <= aux_ctl_r[AUX_STATIC_BIT] ? sticky_r
                                                  : lol_r;
      end
   end

   // ****************************************************************
   // Squelch of the recovered outputs
   // ****************************************************************
   wire sq_mode_w  = out_ctl_r[OUT_SQ_MODE_BIT];
   wire sq_clk_w   = sq_mode_w ? ~squelch_i : squelch_i;
   wire sq_data_w  = squelch_i;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         clk_out_r  <= 1'b0;
         data_out_r <= 1'b0;
      end else begin
         clk_out_r  <= rec_clock_i & ~sq_clk_w;
         data_out_r <= rec_data_i & ~sq_data_w;
      end
   end

   assign sda_o                 = 1'b0;
   assign sda_oe_o              = sda_oe_r;
   assign recovered_clock_out_o = clk_out_r;
   assign recovered_data_out_o  = data_out_r;
   assign loss_of_lock_o        = lol_pin_r;
   assign acq_restart_o         = acq_pulse_r;
   assign ref_lock_en_o         = ref_ctl_r[REF_LOCK_BIT];
   assign fine_rate_en_o        = ref_ctl_r[FINE_RATE_BIT];
   assign ref_range_o           = ref_ctl_r[RANGE_MSB:RANGE_LSB];
   assign ref_ratio_o           = ref_ctl_r[RATIO_MSB:RATIO_LSB];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   property p_start_addr;
      start_w & ~stop_w |=> state_r == ST_ADDR;
   endproperty
   a_start_addr: assert property (p_start_addr)
      else $error("start did not enter address phase");

   property p_stop_idle;
      stop_w |=> state_r == ST_IDLE && !sda_oe_o;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop did not return to idle");

   property p_addr_ack;
      state_r == ST_ADDR && byte_done_w && addr_hit_w && !start_w
         && !stop_w |=> sda_oe_o && state_r == ST_ACK_ADDR;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("own address not acknowledged");

   property p_addr_miss;
      state_r == ST_ADDR && byte_done_w && !addr_hit_w && !start_w
         && !stop_w |=> state_r == ST_IDLE && !sda_oe_o;
   endproperty
   a_addr_miss: assert property (p_addr_miss)
      else $error("foreign address answered");

   property p_bad_sub;
      state_r == ST_SUB && byte_done_w && !sub_ok_w && !start_w
         && !stop_w |=> state_r == ST_IDLE && !sda_oe_o;
   endproperty
   a_bad_sub: assert property (p_bad_sub)
      else $error("invalid subaddress acknowledged");

   property p_harm_off;
      ref_mode_w |=> harm_cnt_r == 0;
   endproperty
   a_harm_off: assert property (p_harm_off)
      else $error("harmonic check ran in reference mode");

   property p_sq_both;
      !sq_mode_w && squelch_i |=> !recovered_clock_out_o
         && !recovered_data_out_o;
   endproperty
   a_sq_both: assert property (p_sq_both)
      else $error("outputs not squelched together");

   property p_sq_split;
      sq_mode_w && !squelch_i |=> !recovered_clock_out_o
         && recovered_data_out_o == $past(rec_data_i);
   endproperty
   a_sq_split: assert property (p_sq_split)
      else $error("split squelch wrong");

   property p_lol_release;
      lol_r && freq_within_i && !set_lol_w |=> !lol_r;
   endproperty
   a_lol_release: assert property (p_lol_release)
      else $error("lock flag not released");

   property p_harm_lol;
      harm_hit_w && !lol_r |=> lol_r && acq_restart_o;
   endproperty
   a_harm_lol: assert property (p_harm_lol)
      else $error("harmonic did not raise lock loss");

   property p_sticky;
      lol_r |=> sticky_r;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("sticky status missed a lock loss");

   property p_rd_park;
      state_r == ST_ACK_RD && ptr_r == SUB_LAST && fall_w && mack_r
         && !start_w && !stop_w |=> ptr_r == SUB_LAST;
   endproperty
   a_rd_park: assert property (p_rd_park)
      else $error("read pointer left the last register");

   property p_lol_pin;
      aux_ctl_r[AUX_STATIC_BIT] |=> loss_of_lock_o == $past(sticky_r);
   endproperty
   a_lol_pin: assert property (p_lol_pin)
      else $error("static lock pin does not mirror sticky status");

endmodule : cdr_control_i2c_slave

// ### bench/i2c_master_model.sv
// Two-wire bus master model that drives the serial register port
`timescale 1ns/10ps
module i2c_master_model #(
   parameter int PH = 4
) (
   input  wire logic clk_sys_i,
   input  wire logic sda_line_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // ********
   // Bus phases, each PH clocks long
   // ********
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic tick();
      repeat (PH) @(posedge clk_sys_i);
      #1;
   endtask : tick
   task automatic start();
      sda_low_o = 1'b1;
      tick();
      scl_o = 1'b0;
      tick();
   endtask : start
   task automatic stop();
      sda_low_o = 1'b1;
      tick();
      scl_o = 1'b1;
      tick();
      sda_low_o = 1'b0;
      tick();
   endtask : stop
   // Data moves only while the clock is low, so no false start or stop
   task automatic xfer(input logic b, output logic r);
      sda_low_o = ~b;
      tick();
      scl_o = 1'b1;
      tick();
      r = sda_line_i;
      tick();
      scl_o = 1'b0;
      tick();
   endtask : xfer
   task automatic byte_io(input logic [7:0] d, input logic ab,
                          output logic [7:0] q, output logic r);
      for (int i = 7; i >= 0; i--) begin
         xfer(d[i], q[i]);
      end
      xfer(ab, r);
   endtask : byte_io
endmodule : i2c_master_model

// ### bench/tb.sv
// Self-checking bench of the CDR control block and its serial port
`timescale 1ns/10ps
module tb;
   import cdr_ctrl_pkg::*;
   localparam int HC = 8;
   logic clk_sys_i, rst_i, scl, sda_low, sda_o, sda_oe, sda_line;
   logic asel, squelch, rclk, rdat, fwin, ferr, harm, dtr;
   logic rco, rdo, loss_of_lock, restart, lock_en, fine_en;
   logic [1:0] range_w;
   logic [3:0] ratio_w;
   logic [7:0] wq[$];
   int mismatches, checks;
   int mreg[8];
   // Pull-up wins unless a party pulls low
   assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
   cdr_control_i2c_slave #(.HARM_COUNT(HC)) u_cdr_control_i2c_slave (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .addr_select_pin_i(asel), .squelch_i(squelch),
      .rec_clock_i(rclk), .rec_data_i(rdat), .freq_within_i(fwin),
      .freq_error_i(ferr), .harm_suspect_i(harm),
      .data_transition_i(dtr), .recovered_clock_out_o(rco),
      .recovered_data_out_o(rdo), .loss_of_lock_o(loss_of_lock),
      .acq_restart_o(restart), .ref_lock_en_o(lock_en),
      .fine_rate_en_o(fine_en), .ref_range_o(range_w),
      .ref_ratio_o(ratio_w));
   i2c_master_model u_i2c_master_model (.clk_sys_i(clk_sys_i),
      .sda_line_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
   always #20 clk_sys_i = ~clk_sys_i;
   // ********
   // Shared tasks
   // ********
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : step
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic send(input logic [7:0] b, output logic a);
      logic [7:0] q;
      logic r;
      u_i2c_master_model.byte_io(b, 1'b1, q, r);
      a = ~r;
   endtask : send
   task automatic wr(input int sub);
      logic a;
      int p;
      p = sub;
      u_i2c_master_model.start();
      send({ADDR_MSB_FIXED, asel, ADDR_LOW_FIXED, 1'b0}, a);
      chk(a, 1);
      send(sub[7:0], a);
      chk(a, sub < NUM_REGS);
      foreach (wq[i]) begin
         send(wq[i], a);
         chk(a, 1);
         if (p < 3) mreg[p] = wq[i];
         if (p < 7) p++;
      end
      u_i2c_master_model.stop();
      wq.delete();
   endtask : wr
   // Last byte is refused by the master to end the read
   task automatic rd(input int sub, input int n);
      logic a, r;
      logic [7:0] q;
      int p;
      p = sub;
      wr(sub);
      u_i2c_master_model.start();
      send({ADDR_MSB_FIXED, asel, ADDR_LOW_FIXED, 1'b1}, a);
      chk(a, 1);
      for (int i = 0; i < n; i++) begin
         u_i2c_master_model.byte_io(8'hFF, i == n - 1, q, r);
         chk(q, mreg[p]);
         if (p < 7) p++;
      end
      u_i2c_master_model.stop();
   endtask : rd
   task automatic tr(input int n);
      repeat (n) begin
         dtr = 1'b1;
         step(1);
         dtr = 1'b0;
         step(1);
      end
   endtask : tr
   task automatic watch(input logic exp_lol, input logic exp_rs);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 3; i++) begin
         step(1);
         seen |= restart;
      end
      chk(loss_of_lock, exp_lol);
      chk(seen, exp_rs);
   endtask : watch
   // ********
   // Main sequence
   // ********
   initial begin
      logic [7:0] v;
      logic a, r, kc;
      {clk_sys_i, squelch, rclk, rdat, fwin, ferr, harm, dtr} = '0;
      rst_i = 1'b1;
      mismatches = 0;
      checks = 0;
      asel = 1'($urandom(32'hC3366AA2));
      repeat (4) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      step(2);
      chk(loss_of_lock, 1);
      chk({range_w, ratio_w, fine_en, lock_en}, 8'h00);
      chk({restart, rco, rdo, sda_oe}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         v[7:6] = i[1:0];
         v[5:2] = 4'($urandom_range(8));
         v[1] = v[1] & ~v[0];
         wq.push_back(v);
         wr(0);
         chk({range_w, ratio_w, fine_en, lock_en}, v);
      end
      wq = '{8'h00, 8'($urandom) & 8'h7F, 8'($urandom)};
      wr(0);
      rd(0, 3);
      rd(5, 4);
      wr(8);
      u_i2c_master_model.start();
      send({ADDR_MSB_FIXED, ~asel, ADDR_LOW_FIXED, 1'b0}, a);
      chk(a, 0);
      u_i2c_master_model.stop();
      u_i2c_master_model.start();
      u_i2c_master_model.xfer(1'b1, r);
      u_i2c_master_model.xfer(1'b0, r);
      u_i2c_master_model.stop();
      rd(1, 1);
      for (int m = 0; m < 2; m++) begin
         wq.push_back(8'(m << OUT_SQ_MODE_BIT));
         wr(2);
         for (int s = 0; s < 2; s++) begin
            squelch = s[0];
            rclk = 1'($urandom);
            rdat = 1'($urandom);
            kc = (m == 0) ? (s == 0) : (s == 1);
            step(2);
            chk(rco, rclk & kc);
            chk(rdo, rdat & ~s[0]);
         end
      end
      fwin = 1'b1;
      watch(0, 0);
      fwin = 1'b0;
      ferr = 1'b1;
      watch(1, 1);
      {ferr, fwin} = 2'b01;
      watch(0, 0);
      {fwin, harm} = 2'b01;
      tr(HC - 1);
      watch(0, 0);
      // Final transition is held so the restart pulse falls inside watch
      dtr = 1'b1;
      watch(1, 1);
      dtr = 1'b0;
      {harm, fwin} = 2'b01;
      watch(0, 0);
      fwin = 1'b0;
      wq.push_back(8'h01);
      wr(0);
      fwin = 1'b1;
      watch(0, 0);
      {fwin, harm} = 2'b01;
      tr(2 * HC);
      watch(0, 0);
      harm = 1'b0;
      // Static indicator: pin shows sticky status until 1 then 0 on bit 6
      wq.push_back(8'hE0);
      wr(1);
      watch(1, 0);
      mreg[3] = 8'h10;
      rd(3, 1);
      wq.push_back(8'hA0);
      wr(1);
      watch(0, 0);
      mreg[3] = 0;
      rd(3, 1);
      summarize();
   end
   initial begin
      #2000000;
      mismatches++;
      summarize();
   end
endmodule : tb
